// ==== logic/sfps_map.svh ====
// constants, opcodes, timing and register map of the serial flash sequencer
`ifndef SFPS_MAP_SVH
`define SFPS_MAP_SVH
// How it works
// R1 - program and wipes need the write-arm latch set by the arm command
// R2 - program frame: opcode, three address bytes, data bytes, select held low
// R3 - data past the page end wraps to the page's first byte
// R4 - more than a page of data keeps only the last 256 bytes
// R5 - short programs touch only addressed bytes of the page
// R6 - select must rise on a byte boundary or the program is dropped
// R7 - select rising starts the timed cycle; busy reads 1 until done
// R8 - write-arm latch clears before the timed cycle completes
// R9 - status reads still work while a cycle runs
// R10 - program into a guarded page is not executed
// R11 - wipes and sleep are opcode only; select must rise after bit eight
// R12 - wipes set every byte to FFh; full wipe lasts erase_cycle_time
// R13 - wipes run only when all three guard bits are zero
// R14 - address bits 23 to 19 are ignored
// R15 - deselect gives standby; deep sleep only via the sleep command
// R16 - deep sleep starts sleep_entry_delay after select rises
// R17 - asleep, only the wake-and-signature command is decoded
// R18 - sleep command during a timed cycle is rejected
// R19 - power-up always lands in standby, never deep sleep
// R20 - identity read shifts out 32 bits on falling edges, fixed byte order
// R21 - identity read during a timed cycle is not decoded
// R22 - select rising ends output and returns to standby
// R23 - every input bit is sampled on the serial clock rising edge
// R24 - opcodes, status bit positions, msb-first order come from tables here
// R25 - program and wipes with latch clear do nothing, busy stays zero

// ----------------------------------------
// opcodes
// ----------------------------------------
`define SFPS_OP_WRITE_ARM   8'h06
`define SFPS_OP_PROGRAM     8'h02
`define SFPS_OP_SECTOR_WIPE 8'hD8
`define SFPS_OP_FULL_WIPE   8'hC7
`define SFPS_OP_SLEEP       8'hB9
`define SFPS_OP_READ_ID     8'h9F
`define SFPS_OP_WAKE        8'hAB
`define SFPS_OP_STATUS      8'h05

// ----------------------------------------
// timing
// ----------------------------------------
`define SFPS_CLK_HZ         20000000
`define SFPS_PROG_TIME_US   1000
`define SFPS_SECT_TIME_US   100000
`define SFPS_BULK_TIME_US   1000000
`define SFPS_SLEEP_TIME_NS  3000
`define SFPS_PROG_CYCLES    (`SFPS_PROG_TIME_US * (`SFPS_CLK_HZ / 1000000))
`define SFPS_SECT_CYCLES    (`SFPS_SECT_TIME_US * (`SFPS_CLK_HZ / 1000000))
`define SFPS_BULK_CYCLES    (`SFPS_BULK_TIME_US * (`SFPS_CLK_HZ / 1000000))
`define SFPS_SLEEP_CYCLES   ((`SFPS_SLEEP_TIME_NS * (`SFPS_CLK_HZ / 1000000) + 999) / 1000)

// ----------------------------------------
// status byte, register map, misc
// ----------------------------------------
`define SFPS_SB_BUSY        0
`define SFPS_SB_ARM         1
`define SFPS_SB_GUARD_LO    2
`define SFPS_RS_SLEEP       2
`define SFPS_RS_PEND        3
`define SFPS_REG_GUARD      8'h00
`define SFPS_REG_STATUS     8'h04
`define SFPS_REG_MEM_ADDR   8'h08
`define SFPS_REG_MEM_DATA   8'h0C
`define SFPS_PAGE_BYTES     256
`define SFPS_ERASED         8'hFF
`define SFPS_PINS_IDLE      3'b010
`endif

// ==== logic/sfps_pkg.sv ====
// types shared by the serial flash sequencer
package sfps_pkg;
  typedef enum logic [2:0] {
    ph_off, ph_op, ph_addr, ph_data, ph_tail, ph_dummy, ph_out, ph_skip
  } sfps_phase_e;
  typedef enum logic [1:0] {cy_none, cy_prog, cy_sect, cy_bulk} sfps_cycle_e;
  typedef enum logic [1:0] {ok_id, ok_status, ok_sig} sfps_out_e;
  typedef struct packed {
    logic sck;
    logic csn;
    logic mosi;
  } sfps_pins_s;
  typedef struct packed {
    logic [7:0] addr;
    logic       write;
    logic       valid;
  } sfps_ahb_s;
endpackage

// ==== logic/sfps_top.sv ====
// serial flash program, wipe, sleep and identity sequencer with ahb-lite window
`timescale 1ns/1ns
`default_nettype none
`include "sfps_map.svh"
module sfps_top
  import sfps_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = `SFPS_PROG_CYCLES,
  parameter int unsigned SECT_CYCLES = `SFPS_SECT_CYCLES,
  parameter int unsigned BULK_CYCLES = `SFPS_BULK_CYCLES,
  parameter int unsigned MEM_PAGES   = 4,
  parameter logic [7:0]  ID_CONT     = 8'hA1, // arbitrary
  parameter logic [7:0]  ID_MAKER    = 8'hB2, // arbitrary
  parameter logic [7:0]  ID_TYPE     = 8'hC3, // arbitrary
  parameter logic [7:0]  ID_CAP      = 8'hD4, // arbitrary
  parameter logic [7:0]  SIG_BYTE    = 8'h5A  // arbitrary
)(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        select_n,
  input  wire logic        serial_clk,
  input  wire logic        data_in,
  output var  logic        data_out,
  output var  logic        data_out_en,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic [31:0] hrdata,
  output var  logic        hreadyout,
  output var  logic        hresp
);

  localparam int unsigned PG_BITS   = $clog2(MEM_PAGES);
  localparam int unsigned MEM_BYTES = MEM_PAGES * `SFPS_PAGE_BYTES;
  localparam int          SLEEP_WAIT = `SFPS_SLEEP_CYCLES;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  sfps_pins_s pin_s1_reg;
  sfps_pins_s pin_s2_reg;
  sfps_pins_s pin_s3_reg;
  sfps_pins_s pin_reg;
  sfps_pins_s pin_prev_reg;
  logic       sck_rise;
  logic       sck_fall;
  logic       cs_rise;
  logic       selected;

  // a change counts only once stages two and three agree
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      pin_s1_reg   <= `SFPS_PINS_IDLE;
      pin_s2_reg   <= `SFPS_PINS_IDLE;
      pin_s3_reg   <= `SFPS_PINS_IDLE;
      pin_reg      <= `SFPS_PINS_IDLE;
      pin_prev_reg <= `SFPS_PINS_IDLE;
    end
    else
    begin
      pin_s1_reg   <= '{sck: serial_clk, csn: select_n, mosi: data_in};
      pin_s2_reg   <= pin_s1_reg;
      pin_s3_reg   <= pin_s2_reg;
      pin_reg      <= (pin_reg & (pin_s2_reg ^ pin_s3_reg)) | (pin_s3_reg & ~(pin_s2_reg ^ pin_s3_reg));
      pin_prev_reg <= pin_reg;
    end
  end

  assign selected = !pin_reg.csn;
  assign sck_rise = pin_reg.sck && !pin_prev_reg.sck && selected;
  assign sck_fall = !pin_reg.sck && pin_prev_reg.sck && selected;
  assign cs_rise  = pin_reg.csn && !pin_prev_reg.csn;

  // ----------------------------------------
  // state and decode
  // ----------------------------------------
  sfps_phase_e       phase_reg;
  sfps_phase_e       dec_phase;
  sfps_cycle_e       cyc_kind_reg;
  sfps_out_e         out_kind_reg;
  sfps_out_e         dec_kind;
  sfps_ahb_s         ahb_req_reg;
  logic [2:0]        bit_cnt_reg;
  logic [1:0]        byte_cnt_reg;
  logic [7:0]        shift_reg;
  logic [7:0]        op_reg;
  logic [23:0]       addr_reg;
  logic [7:0]        col_reg;
  logic [31:0]       out_reg;
  logic [4:0]        out_cnt_reg;
  logic              data_seen_reg;
  logic              wake_seen_reg;
  logic              write_arm_reg;
  logic              sleep_reg;
  logic              sleep_pend_reg;
  logic [7:0]        sleep_cnt_reg;
  logic [31:0]       cyc_cnt_reg;
  logic [2:0]        guard_reg;
  logic [PG_BITS+7:0] mem_idx_reg;
  logic [7:0]        mem_reg [MEM_BYTES];
  logic [7:0]        pbuf_reg [`SFPS_PAGE_BYTES];
  logic              pmask_reg [`SFPS_PAGE_BYTES];
  logic [7:0]        next_byte;
  logic [7:0]        status_byte;
  logic [31:0]       dec_word;
  logic              busy;
  logic              byte_done;
  logic              op_done;
  logic              data_wr;
  logic              arm_set;
  logic              page_guarded;
  logic              tail_end;
  logic              go_prog;
  logic              go_sect;
  logic              go_bulk;
  logic              go_sleep;
  logic              go_wake;
  logic              go_any;
  logic              cyc_done;

  // upper sectors guarded, growing with the guard code
  function automatic logic sfps_guarded(input logic [2:0] g, input logic [2:0] sec);
    case (g)
      3'h0:    return 1'b0;
      3'h1:    return sec == 3'h7;
      3'h2:    return sec >= 3'h6;
      3'h3:    return sec >= 3'h4;
      default: return 1'b1;
    endcase
  endfunction

  assign busy         = cyc_kind_reg != cy_none;
  assign next_byte    = {shift_reg[6:0], pin_reg.mosi}; // R24
  assign byte_done    = sck_rise && bit_cnt_reg == 3'h7;
  assign op_done      = byte_done && phase_reg == ph_op;
  assign data_wr      = byte_done && phase_reg == ph_data;
  assign arm_set      = op_done && !sleep_reg && !busy && next_byte == `SFPS_OP_WRITE_ARM; // R1
  assign page_guarded = sfps_guarded(guard_reg, addr_reg[18:16]); // R14
  assign tail_end     = cs_rise && phase_reg == ph_tail; // R11
  assign go_prog      = cs_rise && phase_reg == ph_data && bit_cnt_reg == 3'h0
                        && data_seen_reg && !page_guarded; // R6 R10
  assign go_sect      = tail_end && op_reg == `SFPS_OP_SECTOR_WIPE && guard_reg == 3'h0; // R13
  assign go_bulk      = tail_end && op_reg == `SFPS_OP_FULL_WIPE && guard_reg == 3'h0; // R13
  assign go_sleep     = tail_end && op_reg == `SFPS_OP_SLEEP; // R15
  assign go_wake      = cs_rise && wake_seen_reg;
  assign go_any       = go_prog || go_sect || go_bulk;
  assign cyc_done     = busy && cyc_cnt_reg == 32'h1;

  always_comb
  begin
    status_byte = 8'h00;
    status_byte[`SFPS_SB_BUSY] = busy; // R24
    status_byte[`SFPS_SB_ARM] = write_arm_reg;
    status_byte[`SFPS_SB_GUARD_LO +: 3] = guard_reg;
  end

  // asleep only wake decodes; busy only status decodes
  always_comb
  begin
    dec_phase = ph_skip;
    dec_kind  = ok_status;
    dec_word  = {status_byte, 24'h0};
    if (sleep_reg)
    begin
      if (next_byte == `SFPS_OP_WAKE) // R17
        dec_phase = ph_dummy;
    end
    else if (busy)
    begin
      if (next_byte == `SFPS_OP_STATUS) // R9 R18 R21
        dec_phase = ph_out;
    end
    else
    begin
      case (next_byte)
        `SFPS_OP_PROGRAM:     dec_phase = write_arm_reg ? ph_addr : ph_skip; // R1 R25
        `SFPS_OP_SECTOR_WIPE: dec_phase = write_arm_reg ? ph_tail : ph_skip; // R25
        `SFPS_OP_FULL_WIPE:   dec_phase = write_arm_reg ? ph_tail : ph_skip;
        `SFPS_OP_SLEEP:       dec_phase = ph_tail;
        `SFPS_OP_WAKE:        dec_phase = ph_dummy;
        `SFPS_OP_STATUS:      dec_phase = ph_out;
        `SFPS_OP_READ_ID:
        begin
          dec_phase = ph_out;
          dec_kind  = ok_id;
          dec_word  = {ID_CONT, ID_MAKER, ID_TYPE, ID_CAP}; // R20
        end
        default:              dec_phase = ph_skip;
      endcase
    end
  end

  // ----------------------------------------
  // serial frame engine
  // ----------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (rst || !selected)
    begin
      phase_reg     <= ph_off; // R15 R22
      bit_cnt_reg   <= 3'h0;
      byte_cnt_reg  <= 2'h0;
      shift_reg     <= 8'h00;
      data_seen_reg <= 1'b0;
    end
    else if (phase_reg == ph_off)
    begin
      phase_reg     <= ph_op;
      wake_seen_reg <= 1'b0;
    end
    else if (sck_rise)
    begin
      bit_cnt_reg <= bit_cnt_reg + 3'h1; // R23
      shift_reg   <= next_byte;
      if (phase_reg == ph_tail)
        phase_reg <= ph_skip; // R11
      else if (byte_done)
      begin
        unique case (phase_reg)
          ph_op:
          begin
            phase_reg     <= dec_phase;
            op_reg        <= next_byte;
            wake_seen_reg <= dec_phase == ph_dummy;
            out_kind_reg  <= dec_kind;
            out_reg       <= dec_word;
            out_cnt_reg   <= 5'h0;
          end
          ph_addr:
          begin
            addr_reg     <= {addr_reg[15:0], next_byte}; // R2
            byte_cnt_reg <= byte_cnt_reg + 2'h1;
            col_reg      <= next_byte;
            if (byte_cnt_reg == 2'h2)
              phase_reg <= ph_data;
          end
          ph_data:
          begin
            col_reg       <= col_reg + 8'h01; // R3 R4
            data_seen_reg <= 1'b1;
          end
          ph_dummy:
          begin
            byte_cnt_reg <= byte_cnt_reg + 2'h1;
            if (byte_cnt_reg == 2'h2)
            begin
              phase_reg    <= ph_out;
              out_kind_reg <= ok_sig;
              out_reg      <= {SIG_BYTE, 24'h0};
              out_cnt_reg  <= 5'h0;
            end
          end
          ph_off, ph_tail, ph_out, ph_skip:
          begin
          end
        endcase
      end
    end
    else if (sck_fall && phase_reg == ph_out)
    begin
      out_cnt_reg <= out_cnt_reg + 5'h1;
      if (out_cnt_reg[2:0] == 3'h7 && out_kind_reg == ok_status)
        out_reg <= {status_byte, 24'h0}; // R9
      else if (out_cnt_reg[2:0] == 3'h7 && out_kind_reg == ok_sig)
        out_reg <= {SIG_BYTE, 24'h0};
      else
        out_reg <= {out_reg[30:0], 1'b0}; // R20
    end
  end

  // output pin; released the cycle after select rises
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      data_out    <= 1'b0;
      data_out_en <= 1'b0;
    end
    else
    begin
      data_out_en <= selected && phase_reg == ph_out; // R22
      if (sck_fall && phase_reg == ph_out)
        data_out <= out_reg[31]; // R20
    end
  end

  // ----------------------------------------
  // timed cycles, latch, sleep
  // ----------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      cyc_kind_reg <= cy_none;
      cyc_cnt_reg  <= 32'h0;
    end
    else if (go_prog)
    begin
      cyc_kind_reg <= cy_prog; // R7
      cyc_cnt_reg  <= PROG_CYCLES;
    end
    else if (go_sect)
    begin
      cyc_kind_reg <= cy_sect;
      cyc_cnt_reg  <= SECT_CYCLES;
    end
    else if (go_bulk)
    begin
      cyc_kind_reg <= cy_bulk;
      cyc_cnt_reg  <= BULK_CYCLES; // R12
    end
    else if (busy)
    begin
      cyc_cnt_reg <= cyc_cnt_reg - 32'h1;
      if (cyc_done)
        cyc_kind_reg <= cy_none; // R7
    end
  end

  // cleared at cycle start, well before completion
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      write_arm_reg <= 1'b0;
    else if (go_any)
      write_arm_reg <= 1'b0; // R8
    else if (arm_set)
      write_arm_reg <= 1'b1; // R1
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      sleep_reg      <= 1'b0; // R19
      sleep_pend_reg <= 1'b0;
      sleep_cnt_reg  <= 8'h00;
    end
    else if (go_wake)
    begin
      sleep_reg      <= 1'b0; // R17
      sleep_pend_reg <= 1'b0;
    end
    else if (go_sleep)
    begin
      sleep_pend_reg <= 1'b1; // R16
      sleep_cnt_reg  <= 8'(SLEEP_WAIT);
    end
    else if (sleep_pend_reg)
    begin
      sleep_cnt_reg <= sleep_cnt_reg - 8'h01;
      if (sleep_cnt_reg == 8'h01)
      begin
        sleep_reg      <= 1'b1; // R16
        sleep_pend_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // page buffer and array model
  // ----------------------------------------
  // array models MEM_PAGES pages, aliased over the full address space
  genvar gi;
  for (gi = 0; gi < `SFPS_PAGE_BYTES; gi++)
  begin : g_buf
    always_ff @(posedge sys_clk)
    begin
      if (rst)
      begin
        pbuf_reg[gi]  <= `SFPS_ERASED;
        pmask_reg[gi] <= 1'b0;
      end
      else if (op_done && dec_phase == ph_addr)
        pmask_reg[gi] <= 1'b0;
      else if (data_wr && col_reg == 8'(gi))
      begin
        pbuf_reg[gi]  <= next_byte; // R4
        pmask_reg[gi] <= 1'b1; // R5
      end
    end
  end

  genvar gj;
  for (gj = 0; gj < MEM_BYTES; gj++)
  begin : g_cell
    always_ff @(posedge sys_clk)
    begin
      if (rst)
        mem_reg[gj] <= `SFPS_ERASED;
      else if (cyc_done && cyc_kind_reg != cy_prog)
        mem_reg[gj] <= `SFPS_ERASED; // R12
      else if (cyc_done && pmask_reg[gj % `SFPS_PAGE_BYTES]
               && addr_reg[PG_BITS+7:8] == PG_BITS'(gj / `SFPS_PAGE_BYTES))
        mem_reg[gj] <= mem_reg[gj] & pbuf_reg[gj % `SFPS_PAGE_BYTES]; // R5
    end
  end

  // ----------------------------------------
  // ahb-lite slave
  // ----------------------------------------
  // zero wait state; a read right after a write sees the old value
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      ahb_req_reg <= '0;
      hrdata      <= 32'h0;
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
    end
    else if (hready)
    begin
      ahb_req_reg <= '{addr: haddr[7:0], write: hwrite,
                       valid: hsel && htrans[1] && hsize == 3'h2 && haddr[31:8] == 24'h0};
      hrdata <= 32'h0;
      if (hsel && htrans[1] && !hwrite && haddr[31:8] == 24'h0)
      begin
        case (haddr[7:0])
          `SFPS_REG_GUARD:    hrdata <= {29'h0, guard_reg};
          `SFPS_REG_STATUS:   hrdata <= {28'h0, sleep_pend_reg, sleep_reg, write_arm_reg, busy};
          `SFPS_REG_MEM_ADDR: hrdata <= 32'(mem_idx_reg);
          `SFPS_REG_MEM_DATA: hrdata <= {24'h0, mem_reg[mem_idx_reg]};
          default:            hrdata <= 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      guard_reg   <= 3'h0;
      mem_idx_reg <= '0;
    end
    else if (ahb_req_reg.valid && ahb_req_reg.write)
    begin
      if (ahb_req_reg.addr == `SFPS_REG_GUARD)
        guard_reg <= hwdata[2:0];
      if (ahb_req_reg.addr == `SFPS_REG_MEM_ADDR)
        mem_idx_reg <= hwdata[PG_BITS+7:0];
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  property p_arm_needed;
    go_any |-> write_arm_reg;
  endproperty
  a_arm_needed: assert property (p_arm_needed) else $error("cycle started without arm"); // R1

  property p_misaligned;
    cs_rise && phase_reg == ph_data && bit_cnt_reg != 3'h0 |=> !busy;
  endproperty
  a_misaligned: assert property (p_misaligned) else $error("partial byte program ran"); // R6

  property p_busy_cause;
    $rose(busy) |-> $past(cs_rise) && $past(write_arm_reg);
  endproperty
  a_busy_cause: assert property (p_busy_cause) else $error("busy without select rise"); // R7

  property p_busy_ends;
    cyc_done |=> !busy ##1 !busy;
  endproperty
  a_busy_ends: assert property (p_busy_ends) else $error("busy did not drop"); // R7

  property p_arm_cleared;
    $fell(busy) |-> !write_arm_reg;
  endproperty
  a_arm_cleared: assert property (p_arm_cleared) else $error("arm latch still set"); // R8

  property p_status_busy;
    busy && op_done && !sleep_reg && next_byte == `SFPS_OP_STATUS |=> phase_reg == ph_out;
  endproperty
  a_status_busy: assert property (p_status_busy) else $error("status refused while busy"); // R9

  property p_guard_prog;
    go_prog |-> !sfps_guarded(guard_reg, addr_reg[18:16]);
  endproperty
  a_guard_prog: assert property (p_guard_prog) else $error("guarded page programmed"); // R10

  property p_tail_extra;
    sck_rise && phase_reg == ph_tail |=> phase_reg == ph_skip ##1 !tail_end;
  endproperty
  a_tail_extra: assert property (p_tail_extra) else $error("overlong opcode kept"); // R11

  property p_erased;
    cyc_done && cyc_kind_reg != cy_prog |=> mem_reg[mem_idx_reg] == `SFPS_ERASED;
  endproperty
  a_erased: assert property (p_erased) else $error("wipe left data"); // R12

  property p_wipe_guard;
    $rose(busy) && cyc_kind_reg != cy_prog |-> $past(guard_reg) == 3'h0;
  endproperty
  a_wipe_guard: assert property (p_wipe_guard) else $error("wipe ran with guard set"); // R13

  property p_sleep_delay;
    $rose(sleep_reg) |-> $past(go_sleep, SLEEP_WAIT + 1);
  endproperty
  a_sleep_delay: assert property (p_sleep_delay) else $error("sleep entry delay wrong"); // R16

  property p_sleep_ignore;
    sleep_reg && op_done && next_byte != `SFPS_OP_WAKE |=> phase_reg == ph_skip;
  endproperty
  a_sleep_ignore: assert property (p_sleep_ignore) else $error("command decoded asleep"); // R17

  property p_release;
    cs_rise |=> !data_out_en ##1 !data_out_en;
  endproperty
  a_release: assert property (p_release) else $error("output kept after deselect"); // R22

endmodule
`default_nettype wire

// ==== test/sfps_host.sv ====
// host spi controller model driving the flash pins
`timescale 1ns/1ns
`default_nettype none
module sfps_host(
  input  wire logic sys_clk,
  input  wire logic data_out,
  input  wire logic data_out_en,
  output var  logic select_n,
  output var  logic serial_clk,
  output var  logic data_in
);
  logic [31:0] rx;
  initial
  begin
    select_n = 1'b1;
    serial_clk = 1'b0;
    data_in = 1'b0;
  end
  // released line toggles so a stale bit never looks valid
  always @(posedge sys_clk)
    if (select_n) data_in <= ~data_in;
  // ---------------------------------
  // one frame: bytes msb first, then clocks with input low
  // ---------------------------------
  task automatic xfer(input logic [7:0] b[$], input int extra);
    int n;
    n = b.size() * 8;
    select_n <= 1'b0;
    @(posedge sys_clk);
    for (int i = 0; i < n + extra; i++)
    begin
      data_in <= (i < n) ? b[i / 8][7 - i % 8] : 1'b0;
      repeat (4) @(posedge sys_clk);
      serial_clk <= 1'b1;
      repeat (4) @(posedge sys_clk);
      // undriven line reads inverted so a stale bit never passes
      rx = {rx[30:0], data_out_en ? data_out : ~data_out};
      serial_clk <= 1'b0;
    end
    repeat (4) @(posedge sys_clk);
    select_n <= 1'b1;
    repeat (8) @(posedge sys_clk);
  endtask
endmodule
`default_nettype wire

// ==== test/sfps_tb_top.sv ====
// self-checking bench for the serial flash sequencer
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin failures++; \
  $display("unexpected at %0t: got %h expected %h", $time, a, b); end end
module sfps_tb_top;
  logic        sys_clk = 1'b0;
  logic        rst     = 1'b1;
  logic [1:0]  htrans  = 2'h0;
  logic        hwrite  = 1'b0;
  logic [31:0] haddr   = 32'h0;
  logic [31:0] hwdata  = 32'h0;
  logic [31:0] r;
  logic [31:0] d;
  logic [31:0] seed    = 32'h2DCF;
  logic [7:0]  mem [1024];
  int          pa [4]  = '{32'h1FE, 32'h1FF, 32'h100, 32'h101};
  int          failures = 0;
  int          checked  = 0;
  wire logic   select_n, serial_clk, data_in, data_out, data_out_en, hreadyout;
  wire logic [31:0] hrdata;
  always #25 sys_clk = ~sys_clk;
  // long cycles shortened, still longer than one status frame
  sfps_top #(.PROG_CYCLES(400), .SECT_CYCLES(500), .BULK_CYCLES(600)) u_sfps_top (
    .sys_clk(sys_clk), .rst(rst), .select_n(select_n), .serial_clk(serial_clk),
    .data_in(data_in), .data_out(data_out), .data_out_en(data_out_en), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp());
  sfps_host u_sfps_host(.sys_clk(sys_clk), .data_out(data_out),
    .data_out_en(data_out_en), .select_n(select_n),
    .serial_clk(serial_clk), .data_in(data_in));
  function automatic logic [31:0] xs;
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic finish_test;
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ---------------------------------
  // ahb-lite single word transfer
  // ---------------------------------
  task automatic ahb(input logic w, input logic [31:0] ad, input logic [31:0] wd);
    int n;
    n = 0;
    htrans <= 2'h2;
    haddr <= ad;
    hwrite <= w;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1 && n++ < 20) @(posedge sys_clk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1 && n++ < 20) @(posedge sys_clk);
    r = hrdata;
    if (n > 19)
    begin
      failures++;
      finish_test();
    end
  endtask
  task automatic stat(input logic [3:0] e);
    ahb(1'b0, 32'h4, 32'h0);
    `CHK(r[3:0], e)
  endtask
  task automatic memchk(input int ad);
    ahb(1'b1, 32'h8, ad);
    ahb(1'b0, 32'hC, 32'h0);
    `CHK(r[7:0], mem[ad])
  endtask
  task automatic wait_idle;
    int i;
    i = 0;
    // always poll afresh; rx may hold bits of an unrelated frame
    do
    begin
      u_sfps_host.xfer('{8'h05}, 8);
      i++;
    end
    while (u_sfps_host.rx[0] !== 1'b0 && i < 100);
    if (u_sfps_host.rx[0] !== 1'b0)
    begin
      failures++;
      finish_test();
    end
  endtask
  initial
  begin
    foreach (mem[i]) mem[i] = 8'hFF;
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    stat(4'h0);
    ahb(1'b0, 32'h10, 32'h0);
    `CHK(r, 32'h0)
    u_sfps_host.xfer('{8'h9F}, 32);
    `CHK(u_sfps_host.rx, 32'hA1B2C3D4)
    `CHK(data_out_en, 1'b0)
    $display("done identity");
    u_sfps_host.xfer('{8'h02, 8'h00, 8'h01, 8'h00, 8'h55}, 0);
    stat(4'h0);
    memchk(32'h100);
    $display("done unarmed program");
    u_sfps_host.xfer('{8'h06}, 0);
    stat(4'h2);
    d = xs();
    u_sfps_host.xfer('{8'h02, 8'hF8, 8'h01, 8'hFE, d[7:0], d[15:8], d[23:16]}, 0);
    u_sfps_host.xfer('{8'h05}, 8);
    `CHK(u_sfps_host.rx[0], 1'b1)
    u_sfps_host.xfer('{8'hB9}, 0);
    wait_idle();
    stat(4'h0);
    mem[32'h1FE] &= d[7:0];
    mem[32'h1FF] &= d[15:8];
    mem[32'h100] &= d[23:16];
    foreach (pa[i]) memchk(pa[i]);
    $display("done wrapped program");
    u_sfps_host.xfer('{8'h06}, 0);
    u_sfps_host.xfer('{8'h02, 8'h00, 8'h00, 8'h00, 8'h00}, 3);
    stat(4'h2);
    ahb(1'b1, 32'h0, 32'h7);
    ahb(1'b0, 32'h0, 32'h0);
    `CHK(r[2:0], 3'h7)
    u_sfps_host.xfer('{8'hD8}, 0);
    u_sfps_host.xfer('{8'h02, 8'h00, 8'h00, 8'h00, 8'h00}, 0);
    stat(4'h2);
    ahb(1'b1, 32'h0, 32'h0);
    u_sfps_host.xfer('{8'hC7}, 1);
    stat(4'h2);
    u_sfps_host.xfer('{8'hC7}, 0);
    u_sfps_host.xfer('{8'h05}, 8);
    `CHK(u_sfps_host.rx[0], 1'b1)
    wait_idle();
    foreach (mem[i]) mem[i] = 8'hFF;
    memchk(32'h1FE);
    $display("done guards and wipe");
    u_sfps_host.xfer('{8'hB9}, 0);
    stat(4'h8);
    repeat (60) @(posedge sys_clk);
    stat(4'h4);
    u_sfps_host.xfer('{8'h06}, 0);
    stat(4'h4);
    u_sfps_host.xfer('{8'hAB}, 32);
    `CHK(u_sfps_host.rx[7:0], 8'h5A)
    stat(4'h0);
    $display("done deep sleep");
    finish_test();
  end
endmodule
`default_nettype wire
